// [rtl/bcss_pkg.sv]
package bcss_pkg;

  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1_000;
  localparam int START_DELAY_US = 1000;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_PER_US;
  localparam int EN_FALL_DEBOUNCE_MS = 2;
  localparam int EN_FALL_DEBOUNCE_CYC = EN_FALL_DEBOUNCE_MS * CLK_PER_MS;
  localparam int EN_LOW_DEBOUNCE_US = 10;
  localparam int EN_LOW_DEBOUNCE_CYC = EN_LOW_DEBOUNCE_US * CLK_PER_US;
  localparam int COMP_DELAY_US = 100;
  localparam int COMP_DELAY_CYC = COMP_DELAY_US * CLK_PER_US;
  localparam int GATE_OK_WINDOW_MS = 15;
  localparam int GATE_OK_WINDOW_CYC = GATE_OK_WINDOW_MS * CLK_PER_MS;
  localparam int CNT_W = 20;

  // Charge timer, counted in timer oscillator periods
  localparam int TMR_W = 22;
  localparam logic [TMR_W-1:0] ABS_TIMEOUT = 22'h1f_ffff;
  localparam logic [TMR_W-1:0] PRECHG_TIMEOUT = ABS_TIMEOUT >> 3;
  localparam logic [TMR_W-1:0] TMR_MAX = 22'h3f_ffff;

  // Register map
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam logic [31:0] REG_TIMER = 32'h0000_0008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_CHARGE_EN_BIT = 0;
  localparam int STATUS_TIMER_EN_BIT = 4;
  localparam int STATUS_GATE_OK_BIT = 5;
  localparam int STATUS_CHG_PIN_BIT = 6;
  localparam int STATUS_FLT_PIN_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SENSE_W = 14;

  typedef enum logic [12:0] {
    ST_OFF      = 13'h0001,
    ST_CHECK    = 13'h0002,
    ST_START    = 13'h0004,
    ST_PRECHG   = 13'h0008,
    ST_CC       = 13'h0010,
    ST_ABS      = 13'h0020,
    ST_FLOAT    = 13'h0040,
    ST_SUSP_PRE = 13'h0080,
    ST_SUSP_CC  = 13'h0100,
    ST_SUSP_ABS = 13'h0200,
    ST_SUSP_FLT = 13'h0400,
    ST_SHUTDOWN = 13'h0800,
    ST_FAULT    = 13'h1000
  } bcss_state_t;

  // Comparator and strap inputs, all active high
  typedef struct packed {
    logic power_good;
    logic hw_fault;
    logic deep_discharge_low;
    logic deep_discharge_high;
    logic fb_above_cv;
    logic taper_detect;
    logic temp_fault;
    logic en_below_falling;
    logic en_below_lower;
    logic headroom_low;
    logic gate_ok;
    logic reverse_detect;
    logic timer_osc;
    logic timer_strap_ref;
  } bcss_sense_t;

  typedef struct packed {
    logic switching_enable;
    logic precharge_current;
    logic gate_pullup;
    logic gate_pulldown;
    logic comp_pulldown;
  } bcss_drive_t;

endpackage

// [rtl/bcss_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module bcss_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bcss_pkg::bcss_sense_t din,
  output var bcss_pkg::bcss_sense_t dout
);
  import bcss_pkg::*;

  logic [SENSE_W-1:0] din_v;
  logic [SENSE_W-1:0] meta;
  logic [SENSE_W-1:0] stable;

  assign din_v = din;
  assign dout = stable;

  genvar i;
  generate
    for (i = 0; i < SENSE_W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[i] <= 1'b0;
          stable[i] <= 1'b0;
        end else begin
          meta[i] <= din_v[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [rtl/bcss_sequencer.sv]
// Functional notes
// - After startup delay: precharge if deeply discharged
// - Precharge exits to CC, clearing timer
// - Precharge timer overrun latches fault
// - Timer off: precharge until discharge threshold
// - CC: timer idle, exit on CV threshold
// - Absorption: taper or timeout goes float
// - Absorption timeout fixed, precharge one eighth
// - Timer off: absorption ends only on taper
// - Float regulates forever, timer idle
// - Temp fault suspends precharge/absorption, timer frozen
// - Temp fault suspends CC/float, returns same
// - Suspend follows temperature with timer off
// - Enable falling: debounced shutdown, gate low
// - Headroom lockout: immediate shutdown
// - Shutdown stops switching; comp low later
// - Enable below lower threshold: short debounce
// - Gate not ok in window: fault
// - Reverse current pulls gate low fast
// - Recovery restarts from charger off
// - Timer strap selects enable or disable
// - Status flags encode charger state
// - Latched fault only cleared by power cycle
`timescale 1ns/100ps
`default_nettype none

module bcss_sequencer #(
  parameter int START_DELAY_CYCLES = bcss_pkg::START_DELAY_CYC,
  parameter int EN_FALL_DEBOUNCE_CYCLES = bcss_pkg::EN_FALL_DEBOUNCE_CYC,
  parameter int COMP_DELAY_CYCLES = bcss_pkg::COMP_DELAY_CYC,
  parameter int GATE_OK_WINDOW_CYCLES = bcss_pkg::GATE_OK_WINDOW_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bcss_pkg::bcss_sense_t sense_raw,
  output var bcss_pkg::bcss_drive_t drive,
  input wire logic charging_status_flag_i,
  output logic charging_status_flag_o,
  output logic charging_status_flag_oe,
  input wire logic float_status_flag_i,
  output logic float_status_flag_o,
  output logic float_status_flag_oe,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import bcss_pkg::*;

  localparam logic [CNT_W-1:0] START_LIM = CNT_W'(START_DELAY_CYCLES);
  localparam logic [CNT_W-1:0] EN_FALL_LIM = CNT_W'(EN_FALL_DEBOUNCE_CYCLES);
  localparam logic [CNT_W-1:0] EN_LOW_LIM = CNT_W'(EN_LOW_DEBOUNCE_CYC);
  localparam logic [CNT_W-1:0] COMP_LIM = CNT_W'(COMP_DELAY_CYCLES);
  localparam logic [CNT_W-1:0] GATE_LIM = CNT_W'(GATE_OK_WINDOW_CYCLES);

  bcss_sense_t sense;
  bcss_state_t state;
  bcss_state_t next_state;
  logic [CNT_W-1:0] start_cnt;
  logic [CNT_W-1:0] en_fall_cnt;
  logic [CNT_W-1:0] en_low_cnt;
  logic [CNT_W-1:0] comp_cnt;
  logic [CNT_W-1:0] gate_cnt;
  logic [TMR_W-1:0] timer_cnt;
  logic timer_en;
  logic timer_osc_d;
  logic timer_tick;
  logic gate_ok_seen;
  logic start_done;
  logic shutdown_req;
  logic gate_fault;
  logic next_gate_pullup;
  logic [31:0] ctrl;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Counts up while run is held, saturating at lim; drops to zero otherwise
  function automatic logic [CNT_W-1:0] sat_count(input logic run,
                                                 input logic [CNT_W-1:0] cnt,
                                                 input logic [CNT_W-1:0] lim);
    if (!run) begin
      return '0;
    end else if (cnt == lim) begin
      return cnt;
    end
    return cnt + 1'b1;
  endfunction

  // States in which the charger is powered up and supervising the input switch
  function automatic logic is_active(input bcss_state_t s);
    return (s == ST_CHECK) || (s == ST_START) || (s == ST_PRECHG) || (s == ST_CC) ||
           (s == ST_ABS) || (s == ST_FLOAT) || (s == ST_SUSP_PRE) ||
           (s == ST_SUSP_CC) || (s == ST_SUSP_ABS) || (s == ST_SUSP_FLT);
  endfunction

  function automatic logic is_charging(input bcss_state_t s);
    return (s == ST_PRECHG) || (s == ST_CC) || (s == ST_ABS) || (s == ST_FLOAT);
  endfunction

  function automatic logic [3:0] state_code(input bcss_state_t s);
    logic [3:0] code;
    code = 4'h0;
    case (s)
      ST_OFF: code = 4'h0;
      ST_CHECK: code = 4'h1;
      ST_START: code = 4'h2;
      ST_PRECHG: code = 4'h3;
      ST_CC: code = 4'h4;
      ST_ABS: code = 4'h5;
      ST_FLOAT: code = 4'h6;
      ST_SUSP_PRE: code = 4'h7;
      ST_SUSP_CC: code = 4'h8;
      ST_SUSP_ABS: code = 4'h9;
      ST_SUSP_FLT: code = 4'ha;
      ST_SHUTDOWN: code = 4'hb;
      ST_FAULT: code = 4'hc;
      default: code = 4'hf;
    endcase
    return code;
  endfunction

  bcss_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(sense_raw),
    .dout(sense)
  );

  // Debounce and delay counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_cnt <= '0;
      en_fall_cnt <= '0;
      en_low_cnt <= '0;
      comp_cnt <= '0;
      gate_cnt <= '0;
    end else begin
      start_cnt <= sat_count(state == ST_START, start_cnt, START_LIM);
      en_fall_cnt <= sat_count(sense.en_below_falling, en_fall_cnt, EN_FALL_LIM);
      en_low_cnt <= sat_count(sense.en_below_lower, en_low_cnt, EN_LOW_LIM);
      comp_cnt <= sat_count(state == ST_SHUTDOWN, comp_cnt, COMP_LIM);
      gate_cnt <= sat_count(drive.gate_pullup && !gate_ok_seen, gate_cnt, GATE_LIM);
    end
  end

  assign start_done = (start_cnt == START_LIM);
  assign shutdown_req = (en_fall_cnt == EN_FALL_LIM) || (en_low_cnt == EN_LOW_LIM) ||
                        sense.headroom_low;
  // Gate must reach ok within the window and stay ok while pulled up
  assign gate_fault = (gate_cnt == GATE_LIM) ||
                      (gate_ok_seen && drive.gate_pullup && !sense.gate_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_ok_seen <= 1'b0;
    end else if (!drive.gate_pullup) begin
      gate_ok_seen <= 1'b0;
    end else if (sense.gate_ok) begin
      gate_ok_seen <= 1'b1;
    end
  end

  // Strap is caught while the power-up check runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_en <= 1'b0;
    end else if (state == ST_CHECK) begin
      timer_en <= !sense.timer_strap_ref;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_osc_d <= 1'b0;
    end else begin
      timer_osc_d <= sense.timer_osc;
    end
  end

  assign timer_tick = sense.timer_osc && !timer_osc_d;

  // Charge timer: runs only in precharge and absorption, frozen in suspend
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_cnt <= '0;
    end else if (state == ST_OFF || (state == ST_PRECHG && next_state == ST_CC) ||
                 (state == ST_ABS && next_state == ST_FLOAT)) begin
      timer_cnt <= '0;
    end else if (timer_en && timer_tick && timer_cnt != TMR_MAX &&
                 (state == ST_PRECHG || state == ST_ABS)) begin
      timer_cnt <= timer_cnt + 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (sense.power_good && ctrl[CTRL_CHARGE_EN_BIT] && !shutdown_req) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        next_state = sense.hw_fault ? ST_FAULT : ST_START;
      end
      ST_START: begin
        if (start_done) begin
          next_state = sense.deep_discharge_low ? ST_PRECHG : ST_CC;
        end
      end
      ST_PRECHG: begin
        if (sense.temp_fault) begin
          next_state = ST_SUSP_PRE;
        end else if (timer_en && timer_cnt > PRECHG_TIMEOUT) begin
          next_state = ST_FAULT;
        end else if (sense.deep_discharge_high) begin
          next_state = ST_CC;
        end
      end
      ST_CC: begin
        if (sense.temp_fault) begin
          next_state = ST_SUSP_CC;
        end else if (sense.fb_above_cv) begin
          next_state = ST_ABS;
        end
      end
      ST_ABS: begin
        if (sense.temp_fault) begin
          next_state = ST_SUSP_ABS;
        end else if (sense.taper_detect || (timer_en && timer_cnt > ABS_TIMEOUT)) begin
          next_state = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        if (sense.temp_fault) begin
          next_state = ST_SUSP_FLT;
        end
      end
      ST_SUSP_PRE: begin
        if (!sense.temp_fault) begin
          next_state = ST_PRECHG;
        end
      end
      ST_SUSP_CC: begin
        if (!sense.temp_fault) begin
          next_state = ST_CC;
        end
      end
      ST_SUSP_ABS: begin
        if (!sense.temp_fault) begin
          next_state = ST_ABS;
        end
      end
      ST_SUSP_FLT: begin
        if (!sense.temp_fault) begin
          next_state = ST_FLOAT;
        end
      end
      ST_SHUTDOWN: begin
        if (!shutdown_req) begin
          next_state = ST_OFF;
        end
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // A latched fault outranks a shutdown arriving in the same cycle
    if (is_active(state) && next_state != ST_FAULT) begin
      if (gate_fault) begin
        next_state = ST_FAULT;
      end else if (shutdown_req) begin
        next_state = ST_SHUTDOWN;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Pull-up needs headroom; reverse current drops it at once
  assign next_gate_pullup = is_active(next_state) && !sense.headroom_low &&
                            !sense.reverse_detect;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else begin
      drive.switching_enable <= is_charging(next_state);
      drive.precharge_current <= (next_state == ST_PRECHG);
      drive.gate_pullup <= next_gate_pullup;
      drive.gate_pulldown <= !next_gate_pullup;
      drive.comp_pulldown <= (state == ST_SHUTDOWN) && (comp_cnt == COMP_LIM);
    end
  end

  // Open-drain flags: enable high pulls the pin low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charging_status_flag_o <= 1'b0;
      charging_status_flag_oe <= 1'b0;
      float_status_flag_o <= 1'b0;
      float_status_flag_oe <= 1'b0;
    end else begin
      charging_status_flag_o <= 1'b0;
      float_status_flag_o <= 1'b0;
      charging_status_flag_oe <= is_charging(next_state);
      float_status_flag_oe <= (next_state == ST_FLOAT) || (next_state == ST_FAULT) ||
                              (next_state == ST_SUSP_PRE) || (next_state == ST_SUSP_CC) ||
                              (next_state == ST_SUSP_ABS) || (next_state == ST_SUSP_FLT);
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == REG_CTRL || aw_addr == REG_STATUS || aw_addr == REG_TIMER) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Only the charge enable bit is writable; it steers power-up from off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
                 aw_addr == REG_CTRL && w_strb[0]) begin
      ctrl[CTRL_CHARGE_EN_BIT] <= w_data[CTRL_CHARGE_EN_BIT];
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == REG_STATUS) begin
        s_axi_rdata <= '0;
        s_axi_rdata[3:0] <= state_code(state);
        s_axi_rdata[STATUS_TIMER_EN_BIT] <= timer_en;
        s_axi_rdata[STATUS_GATE_OK_BIT] <= gate_ok_seen;
        s_axi_rdata[STATUS_CHG_PIN_BIT] <= charging_status_flag_i;
        s_axi_rdata[STATUS_FLT_PIN_BIT] <= float_status_flag_i;
      end else if (s_axi_araddr == REG_TIMER) begin
        s_axi_rdata <= {{(32 - TMR_W){1'b0}}, timer_cnt};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [dv/bcss_sequencer_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module bcss_sequencer_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bcss_pkg::bcss_sense_t sense_raw,
  input wire bcss_pkg::bcss_drive_t drive,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  import bcss_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_head_low;
    sense_raw.headroom_low [*5];
  endsequence
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_B_STANDS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready during response");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_R_STANDS: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready during response");
  AST_HEAD_STOP: assert property (s_head_low |-> !drive.switching_enable)
    else $error("switching during headroom lockout");
  AST_HEAD_GATE: assert property (s_head_low |-> !drive.gate_pullup)
    else $error("gate pulled up during headroom lockout");
  AST_REV_GATE: assert property (sense_raw.reverse_detect [*5] |-> drive.gate_pulldown)
    else $error("gate not pulled down on reverse current");
  AST_GATE_PAIR: assert property ($past(aresetn) |-> drive.gate_pulldown != drive.gate_pullup)
    else $error("gate pull-up and pull-down agree");
  AST_COMP_LATE: assert property ($rose(drive.comp_pulldown) |-> !$past(drive.switching_enable, 5))
    else $error("compensation pulled low too early");
endmodule
`default_nettype wire

// [dv/bcss_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bcss_far_model (
  input wire logic aclk,
  input wire logic tmr_run,
  input wire logic gate_stuck,
  input wire logic gate_pullup,
  input wire logic chg_o,
  input wire logic chg_oe,
  input wire logic flt_o,
  input wire logic flt_oe,
  output logic timer_osc,
  output logic gate_ok,
  output logic chg_pin,
  output logic flt_pin
);
  logic [1:0] gate_dly = 2'h0;
  initial timer_osc = 1'b0;
  // Timer capacitor oscillates only when not strapped to the reference
  always @(posedge aclk) timer_osc <= tmr_run ? ~timer_osc : timer_osc;
  // Gate charges in two cycles unless the external switch is faulty
  always @(posedge aclk) gate_dly <= {gate_dly[0], gate_pullup && !gate_stuck};
  assign gate_ok = gate_dly[1];
  // Open-drain status pins with pull-ups
  assign chg_pin = chg_oe ? chg_o : 1'b1;
  assign flt_pin = flt_oe ? flt_o : 1'b1;
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bcss_pkg::*;
  logic aclk = 1'b0;
  logic aresetn;
  bcss_sense_t sn, mix;
  bcss_drive_t drv;
  logic tmr_run, gate_stuck, osc, gok, chg_o, chg_oe, flt_o, flt_oe, chg_pin, flt_pin;
  logic [31:0] awaddr, wdata, araddr, rdata, rd, t0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #10 aclk = ~aclk;
  always_comb begin
    mix = sn;
    mix.timer_osc = osc;
    mix.gate_ok = gok;
  end
  bcss_sequencer #(.START_DELAY_CYCLES(20), .EN_FALL_DEBOUNCE_CYCLES(30),
    .COMP_DELAY_CYCLES(10), .GATE_OK_WINDOW_CYCLES(40)) u_bcss_sequencer (
    .aclk(aclk), .aresetn(aresetn), .sense_raw(mix), .drive(drv),
    .charging_status_flag_i(chg_pin), .charging_status_flag_o(chg_o),
    .charging_status_flag_oe(chg_oe), .float_status_flag_i(flt_pin),
    .float_status_flag_o(flt_o), .float_status_flag_oe(flt_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bcss_far_model u_bcss_far_model (.aclk(aclk), .tmr_run(tmr_run), .gate_stuck(gate_stuck),
    .gate_pullup(drv.gate_pullup), .chg_o(chg_o), .chg_oe(chg_oe), .flt_o(flt_o),
    .flt_oe(flt_oe), .timer_osc(osc), .gate_ok(gok), .chg_pin(chg_pin), .flt_pin(flt_pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got_a, got_r;
    got_a = 1'b0;
    got_r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got_r) begin
      @(negedge aclk);
      got_a = got_a || (arvalid && arready);
      got_r = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (got_a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got_aw, got_w, got_b;
    got_aw = 1'b0;
    got_w = 1'b0;
    got_b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got_b) begin
      @(negedge aclk);
      got_aw = got_aw || (awvalid && awready);
      got_w = got_w || (wvalid && wready);
      got_b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (got_aw) awvalid <= 1'b0;
      if (got_w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic wait_state(input logic [3:0] c);
    int i;
    i = 0;
    rd = {28'h0, ~c};
    while (rd[3:0] !== c && i < 400) begin
      rd_reg(REG_STATUS, rd, rsp);
      i++;
    end
    repeat (3) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
  endtask
  task automatic rd_timer();
    rd_reg(REG_TIMER, rd, rsp);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    aresetn = 1'b0;
    sn = '0;
    tmr_run = 1'b0;
    gate_stuck = 1'b0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hcf, 32'hc0);
    rd_reg(32'h0000_000c, rd, rsp);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr_reg(32'h0000_0010, 32'h1, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr_reg(REG_CTRL, 32'h0, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    sn.power_good <= 1'b1;
    sn.deep_discharge_low <= 1'b1;
    tmr_run <= 1'b1;
    repeat (40) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hf, 32'h0);
    wr_reg(REG_CTRL, 32'h1, rsp);
    wait_state(4'h3);
    check(rd & 32'hdf, 32'h93);
    check({30'h0, drv.switching_enable, drv.precharge_current}, 32'h3);
    rd_timer();
    check({31'h0, rd != 0}, 32'h1);
    sn.temp_fault <= 1'b1;
    wait_state(4'h7);
    check(rd & 32'hdf, 32'h57);
    rd_timer();
    t0 = rd;
    repeat (20) @(posedge aclk);
    rd_timer();
    check(rd, t0);
    sn.temp_fault <= 1'b0;
    wait_state(4'h3);
    check(rd & 32'hdf, 32'h93);
    rd_timer();
    check({31'h0, rd > t0}, 32'h1);
    sn.deep_discharge_low <= 1'b0;
    sn.deep_discharge_high <= 1'b1;
    wait_state(4'h4);
    check(rd & 32'hdf, 32'h94);
    check({31'h0, drv.precharge_current}, 32'h0);
    repeat (20) @(posedge aclk);
    rd_timer();
    check(rd, 32'h0);
    sn.temp_fault <= 1'b1;
    wait_state(4'h8);
    check(rd & 32'hdf, 32'h58);
    sn.temp_fault <= 1'b0;
    wait_state(4'h4);
    check(rd & 32'hdf, 32'h94);
    sn.fb_above_cv <= 1'b1;
    wait_state(4'h5);
    check(rd & 32'hdf, 32'h95);
    repeat (20) @(posedge aclk);
    rd_timer();
    check({31'h0, rd != 0}, 32'h1);
    sn.taper_detect <= 1'b1;
    wait_state(4'h6);
    check(rd & 32'hdf, 32'h16);
    repeat (50) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hdf, 32'h16);
    rd_timer();
    check(rd, 32'h0);
    sn.headroom_low <= 1'b1;
    wait_state(4'hb);
    check(rd & 32'h1f, 32'h1b);
    check({30'h0, drv.switching_enable, drv.gate_pulldown}, 32'h1);
    repeat (15) @(posedge aclk);
    check({31'h0, drv.comp_pulldown}, 32'h1);
    sn.power_good <= 1'b0;
    sn.headroom_low <= 1'b0;
    wait_state(4'h0);
    check(rd & 32'hf, 32'h0);
    tmr_run <= 1'b0;
    sn <= '{power_good: 1'b1, deep_discharge_low: 1'b1, timer_strap_ref: 1'b1, default: 1'b0};
    wait_state(4'h3);
    check(rd & 32'hdf, 32'h83);
    repeat (50) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hdf, 32'h83);
    sn.deep_discharge_low <= 1'b0;
    sn.deep_discharge_high <= 1'b1;
    sn.fb_above_cv <= 1'b1;
    wait_state(4'h5);
    check(rd & 32'hdf, 32'h85);
    sn.temp_fault <= 1'b1;
    wait_state(4'h9);
    check(rd & 32'hdf, 32'h49);
    sn.temp_fault <= 1'b0;
    wait_state(4'h5);
    check(rd & 32'hdf, 32'h85);
    sn.taper_detect <= 1'b1;
    wait_state(4'h6);
    check(rd & 32'hdf, 32'h06);
    sn.en_below_falling <= 1'b1;
    repeat (10) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hf, 32'h6);
    wait_state(4'hb);
    check({30'h0, drv.switching_enable, drv.gate_pulldown}, 32'h1);
    sn.power_good <= 1'b0;
    sn.en_below_falling <= 1'b0;
    wait_state(4'h0);
    sn.power_good <= 1'b1;
    wait_state(4'h6);
    sn.reverse_detect <= 1'b1;
    repeat (8) @(posedge aclk);
    check({31'h0, drv.gate_pulldown}, 32'h1);
    sn.reverse_detect <= 1'b0;
    repeat (20) @(posedge aclk);
    check({31'h0, drv.gate_pulldown}, 32'h0);
    sn.en_below_lower <= 1'b1;
    repeat (100) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hf, 32'h6);
    wait_state(4'hb);
    check({31'h0, drv.gate_pulldown}, 32'h1);
    sn.power_good <= 1'b0;
    sn.en_below_lower <= 1'b0;
    wait_state(4'h0);
    gate_stuck <= 1'b1;
    sn.power_good <= 1'b1;
    wait_state(4'hc);
    check(rd & 32'hdf, 32'h4c);
    sn.power_good <= 1'b0;
    gate_stuck <= 1'b0;
    repeat (50) @(posedge aclk);
    rd_reg(REG_STATUS, rd, rsp);
    check(rd & 32'hdf, 32'h4c);
    tally_and_finish();
  end
endmodule
bind bcss_sequencer bcss_sequencer_sva u_bcss_sequencer_sva (.aclk, .aresetn, .sense_raw,
  .drive, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
